// ### rtl/bfc_flash_ctrl.v
// Host controller driving the parallel flash pins, with AHB-Lite registers
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "bfc_defines.vh"
module bfc_flash_ctrl
(
   hclk,
   hresetn,
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hreadyout,
   hresp,
   hrdata,
   fl_addr,
   fl_dq_in,
   fl_dq_out,
   fl_dq_oe,
   fl_top_in,
   fl_top_out,
   fl_top_oe,
   fl_chip_select_n,
   fl_output_enable_n,
   fl_write_strobe_n,
   fl_word_mode,
   fl_write_protect,
   fl_unlock_high_voltage,
   fl_program_supply_en,
   fl_reset_powerdown_n,
   fl_id_high_voltage
);
   input  wire        hclk;                // System clock, 10 MHz
   input  wire        hresetn;             // Asynchronous reset, active low
   input  wire        hsel;                // Slave select
   input  wire [31:0] haddr;               // Bus address
   input  wire [1:0]  htrans;              // Transfer type
   input  wire        hwrite;              // Write when high
   input  wire [2:0]  hsize;               // Transfer size
   input  wire [31:0] hwdata;              // Write data
   input  wire        hready;              // Bus ready
   output reg         hreadyout;           // Slave ready
   output reg         hresp;               // Always OKAY
   output reg  [31:0] hrdata;              // Read data
   output reg  [16:0] fl_addr;             // Flash address A16..A0
   input  wire [14:0] fl_dq_in;            // Data lines 0..14 in
   output reg  [14:0] fl_dq_out;           // Data lines 0..14 out
   output reg         fl_dq_oe;            // Data line drive enable
   input  wire        fl_top_in;           // Top data or low address in
   output reg         fl_top_out;          // Top data or low address out
   output reg         fl_top_oe;           // Top pin drive enable
   output reg         fl_chip_select_n;    // Chip select, active low
   output reg         fl_output_enable_n;  // Output enable, active low
   output reg         fl_write_strobe_n;   // Write strobe, active low
   output reg         fl_word_mode;        // Bus width select, high = 16
   output reg         fl_write_protect;    // Write protect pin level
   output reg         fl_unlock_high_voltage; // Raise reset pin to 12 V
   output reg         fl_program_supply_en;   // Program supply switch
   output reg         fl_reset_powerdown_n;   // Reset/power-down, low
   output reg         fl_id_high_voltage;     // Id voltage on address pin

   // Sequencer states
   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_SETUP = 3'h1;
   localparam [2:0] S_STRB  = 3'h2;
   localparam [2:0] S_HOLD  = 3'h3;
   localparam [2:0] S_READ  = 3'h4;
   localparam [2:0] S_POLL  = 3'h5;
   localparam [2:0] S_DONE  = 3'h6;

   reg        pend_q;                 // AHB write data phase pending
   reg [7:0]  waddr_q;                // Latched AHB write offset
   reg [2:0]  op_q;                   // Operation in progress
   reg        busy_q;                 // Sequencer running
   reg [2:0]  state_q;                // Sequencer state
   reg [1:0]  step_q;                 // Bus cycle index inside operation
   reg [17:0] addr_q;                 // Target byte/word address
   reg [15:0] wdata_q;                // Data word to write in the program cycle
   reg [15:0] rdata_q;                // Last data read
   reg [7:0]  fstat_q;                // Last flash status read
   reg        err_q;                  // Operation ended with error bits
   reg [5:0]  pins_q;                 // Pin control register
   reg        tstart_q;               // Timer start pulse
   reg [3:0]  tcount_q;               // Timer load value
   wire       tdone;                  // Timer expired

   // Command cycle decode: cmd codes per op and step
   function [7:0] bfc_code;
      input [2:0] op;
      input [1:0] step;
      begin
         case (op)
            `BFC_OP_PROG:   bfc_code = `BFC_CMD_PROG;
            `BFC_OP_ERASE:  bfc_code = (step == 2'h0) ? `BFC_CMD_ERASE
                                                      : `BFC_CMD_CONFIRM;
            `BFC_OP_STATUS: bfc_code = `BFC_CMD_STATUS;
            `BFC_OP_CLRST:  bfc_code = `BFC_CMD_CLRST;
            `BFC_OP_ID:     bfc_code = `BFC_CMD_ID;
            `BFC_OP_READ:   bfc_code = `BFC_CMD_READ;
            default:        bfc_code = 8'h00;
         endcase
      end
   endfunction

   // Phase timer shared by all bus cycles
   bfc_pin_timer u_timer
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (tstart_q),
      .count   (tcount_q),
      .done    (tdone)
   );

   wire take = hsel & hready & htrans[1];

   // AHB-Lite slave, zero wait states
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pend_q    <= 1'b0;
         waddr_q   <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end
      else
      begin
         pend_q <= take & hwrite;
         if (take)
         begin
            waddr_q <= haddr[7:0];
         end
         // Read data for the data phase
         if (take && !hwrite)
         begin
            if (haddr[7:0] == `BFC_REG_CTRL)
               hrdata <= {28'h0, op_q, busy_q};
            else if (haddr[7:0] == `BFC_REG_ADDR)
               hrdata <= {14'h0, addr_q};
            else if (haddr[7:0] == `BFC_REG_WDATA)
               hrdata <= {16'h0, wdata_q};
            else if (haddr[7:0] == `BFC_REG_RDATA)
               hrdata <= {16'h0, rdata_q};
            else if (haddr[7:0] == `BFC_REG_STAT)
               hrdata <= {22'h0, err_q, busy_q, fstat_q};
            else if (haddr[7:0] == `BFC_REG_PINS)
               hrdata <= {26'h0, pins_q};
            else
               hrdata <= 32'h0000_0000;
         end
      end
   end

   wire go_wr = pend_q & (waddr_q == `BFC_REG_CTRL) &
                hwdata[`BFC_CTRL_GO] & !busy_q;
   wire bb   = fl_word_mode ? 1'b0 : 1'b1;  // Byte mode flag
   wire [7:0] sr_now = fl_dq_in[7:0];

   // Sequencer: drives flash pins through command and data cycles
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         op_q     <= `BFC_OP_READ;
         busy_q   <= 1'b0;
         state_q  <= S_IDLE;
         step_q   <= 2'h0;
         addr_q   <= 18'h0_0000;
         wdata_q  <= 16'h0000;
         rdata_q  <= 16'h0000;
         fstat_q  <= 8'h00;
         err_q    <= 1'b0;
         pins_q   <= `BFC_PINS_RESET;
         tstart_q <= 1'b0;
         tcount_q <= 4'h0;
         fl_addr  <= 17'h0_0000;
         fl_dq_out <= 15'h0000;
         fl_dq_oe  <= 1'b0;
         fl_top_out <= 1'b0;
         fl_top_oe  <= 1'b0;
         fl_chip_select_n   <= 1'b1;
         fl_output_enable_n <= 1'b1;
         fl_write_strobe_n  <= 1'b1;
         fl_word_mode           <= 1'b1;
         fl_write_protect       <= 1'b0;
         fl_unlock_high_voltage <= 1'b0;
         fl_program_supply_en   <= 1'b0;
         fl_reset_powerdown_n   <= 1'b1;
         fl_id_high_voltage     <= 1'b0;
      end
      else
      begin
         tstart_q <= 1'b0;
         // Idle register writes; pins follow PINS
         if (pend_q && !busy_q)
         begin
            if (waddr_q == `BFC_REG_ADDR)
               addr_q <= hwdata[17:0];
            else if (waddr_q == `BFC_REG_WDATA)
               wdata_q <= hwdata[15:0];
            else if (waddr_q == `BFC_REG_PINS)
               pins_q <= hwdata[5:0];
         end
         fl_word_mode           <= pins_q[`BFC_PIN_WORD];
         fl_program_supply_en   <= pins_q[`BFC_PIN_VPP];
         fl_reset_powerdown_n   <= pins_q[`BFC_PIN_RSTN];
         fl_id_high_voltage     <= pins_q[`BFC_PIN_IDHV];
         fl_write_protect       <= pins_q[`BFC_PIN_WP];
         fl_unlock_high_voltage <= pins_q[`BFC_PIN_UNLOCK];
         case (state_q)
            S_IDLE:
            begin
               if (go_wr)
               begin
                  op_q    <= hwdata[`BFC_CTRL_OP_HI:`BFC_CTRL_OP_LO];
                  busy_q  <= 1'b1;
                  err_q   <= 1'b0;
                  step_q  <= 2'h0;
                  state_q <= S_SETUP;
               end
            end
            S_SETUP:
            begin
               // Address stable; command on low byte or data
               fl_addr   <= addr_q[17:1];
               fl_top_out <= addr_q[0];
               fl_top_oe  <= bb;
               fl_chip_select_n <= 1'b0;
               fl_output_enable_n <= 1'b1;
               if (op_q == `BFC_OP_PROG && step_q == 2'h1)
               begin
                  // Data cycle after setup; at the target address
                  // Erased bits only cleared by the flash
                  fl_dq_out <= bb ? {7'h00, wdata_q[7:0]} : wdata_q[14:0];
                  fl_top_out <= bb ? addr_q[0] : wdata_q[15];
                  fl_top_oe  <= 1'b1;
                  fl_dq_oe   <= 1'b1;
                  fl_write_strobe_n <= 1'b0;
                  state_q <= S_STRB;
               end
               else if (step_q == 2'h1 && (op_q == `BFC_OP_READ ||
                        op_q == `BFC_OP_STATUS || op_q == `BFC_OP_ID))
               begin
                  // Any read: write high, enables low
                  fl_top_oe <= bb;
                  fl_dq_oe  <= 1'b0;
                  fl_output_enable_n <= 1'b0;
                  state_q <= S_READ;
               end
               else
               begin
                  fl_dq_out <= {7'h00, bfc_code(op_q, step_q)};
                  fl_dq_oe  <= 1'b1;
                  fl_write_strobe_n <= 1'b0;
                  state_q <= S_STRB;
               end
               tstart_q <= 1'b1;
               tcount_q <= (step_q == 2'h1) ? `BFC_ACC_CYC : `BFC_PULSE_CYC;
            end
            S_STRB:
            begin
               // Strobe rises first: device latches here
               if (tdone && !tstart_q)
               begin
                  fl_write_strobe_n <= 1'b1;
                  state_q <= S_HOLD;
               end
            end
            S_HOLD:
            begin
               fl_chip_select_n <= 1'b1;
               fl_dq_oe  <= 1'b0;
               fl_top_oe <= bb;
               step_q <= step_q + 2'h1;
               // Two-cycle ops go on; writes then poll status
               if ((op_q == `BFC_OP_PROG || op_q == `BFC_OP_ERASE)
                   && step_q == 2'h1)
                  state_q <= S_POLL;
               else if (op_q == `BFC_OP_CMD || op_q == `BFC_OP_CLRST)
                  state_q <= S_DONE;
               else
                  state_q <= S_SETUP;
            end
            S_READ:
            begin
               if (tdone && !tstart_q)
               begin
                  rdata_q <= (op_q == `BFC_OP_READ && !bb) ?
                             {fl_top_in, fl_dq_in} :
                             {8'h00, fl_dq_in[7:0]};
                  if (op_q == `BFC_OP_STATUS)
                     fstat_q <= sr_now;
                  fl_output_enable_n <= 1'b1;
                  fl_chip_select_n   <= 1'b1;
                  state_q <= S_DONE;
               end
            end
            S_POLL:
            begin
               // Fresh enable fall each poll latches new status
               if (fl_output_enable_n)
               begin
                  fl_chip_select_n   <= 1'b0;
                  fl_output_enable_n <= 1'b0;
                  tstart_q <= 1'b1;
                  tcount_q <= `BFC_ACC_CYC;
               end
               else if (tdone && !tstart_q)
               begin
                  fl_output_enable_n <= 1'b1;
                  fl_chip_select_n   <= 1'b1;
                  fstat_q <= sr_now;
                  // Ready bit high: engine finished
                  if (sr_now[`BFC_SR_READY])
                  begin
                     err_q <= sr_now[`BFC_SR_ERASE_ERR] |
                              sr_now[`BFC_SR_WRITE_ERR] |
                              sr_now[`BFC_SR_NO_VPP];
                     state_q <= S_DONE;
                  end
               end
            end
            S_DONE:
            begin
               busy_q  <= 1'b0;
               state_q <= S_IDLE;
            end
            default:
            begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
   // Block layout, per-block unlock and busy command limits are the
   // device's own concern
endmodule // bfc_flash_ctrl

// ### rtl/bfc_defines.vh
// Constants for the flash bus controller: register map, fields, timing
// Functional notes
// - Boot writes need supply plus unlock or protect
// - Host holds unlock level through boot operations
// - Read with write high, enables low
// - Status latched on later enable fall; toggle refreshes
// - Command on low byte, latched on first rise
// - Program cycle follows setup command, needs supply
// - Program setup code is 40H or 10H
// - Read-array command needed before array reads
`ifndef BFC_DEFINES_VH
`define BFC_DEFINES_VH

// Register byte offsets on the AHB-Lite slave
`define BFC_REG_CTRL     8'h00
`define BFC_REG_ADDR     8'h04
`define BFC_REG_WDATA    8'h08
`define BFC_REG_RDATA    8'h0C
`define BFC_REG_STAT     8'h10
`define BFC_REG_PINS     8'h14

// Control register fields
`define BFC_CTRL_GO      0
`define BFC_CTRL_OP_LO   1
`define BFC_CTRL_OP_HI   3

// Operation codes in the control register
`define BFC_OP_READ      3'h0
`define BFC_OP_CMD       3'h1
`define BFC_OP_PROG      3'h2
`define BFC_OP_ERASE     3'h3
`define BFC_OP_STATUS    3'h4
`define BFC_OP_CLRST     3'h5
`define BFC_OP_ID        3'h6

// Pin control register fields
`define BFC_PIN_WORD     0
`define BFC_PIN_WP       1
`define BFC_PIN_UNLOCK   2
`define BFC_PIN_VPP      3
`define BFC_PIN_RSTN     4
`define BFC_PIN_IDHV     5
`define BFC_PINS_RESET   6'h11

// Flash command codes
`define BFC_CMD_READ     8'hFF
`define BFC_CMD_ID       8'h90
`define BFC_CMD_STATUS   8'h70
`define BFC_CMD_CLRST    8'h50
`define BFC_CMD_ERASE    8'h20
`define BFC_CMD_CONFIRM  8'hD0
`define BFC_CMD_PROG     8'h40
`define BFC_CMD_PROG_ALT 8'h10

// Status bits of the flash
`define BFC_SR_READY     7
`define BFC_SR_SUSP      6
`define BFC_SR_ERASE_ERR 5
`define BFC_SR_WRITE_ERR 4
`define BFC_SR_NO_VPP    3

// Access and pulse times in ns; each rounds up to one 100 ns cycle
`define BFC_ACC_NS       80
`define BFC_PULSE_NS     60
`define BFC_ACC_CYC      4'h1
`define BFC_PULSE_CYC    4'h1

`endif

// ### rtl/bfc_pin_timer.v
// Cycle timer that paces each phase of a flash bus cycle
`timescale 1ns/100ps
module bfc_pin_timer
(
   hclk,
   hresetn,
   start,
   count,
   done
);
   input  wire       hclk;     // System clock
   input  wire       hresetn;  // Asynchronous reset, active low
   input  wire       start;    // Load the count
   input  wire [3:0] count;    // Cycles to wait
   output reg        done;     // High when count has expired

   reg [3:0] cnt_q;            // Remaining cycles

   // Load on start, count down, flag at zero
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_q <= 4'h0;
         done  <= 1'b0;
      end
      else if (start)
      begin
         cnt_q <= count;
         done  <= 1'b0;
      end
      else if (cnt_q != 4'h0)
      begin
         cnt_q <= cnt_q - 4'h1;
         done  <= (cnt_q == 4'h1);
      end
      else
      begin
         done  <= 1'b1;
      end
   end
endmodule // bfc_pin_timer

// ### sim/bfc_flash_ctrl_properties.sv
// Pin and bus checks for the flash controller
`timescale 1ns/100ps
module bfc_flash_ctrl_properties
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [16:0] fl_addr,
   input wire logic [14:0] fl_dq_out,
   input wire logic        fl_dq_oe,
   input wire logic        fl_top_oe,
   input wire logic        fl_chip_select_n,
   input wire logic        fl_output_enable_n,
   input wire logic        fl_write_strobe_n,
   input wire logic        fl_word_mode
);
   // One clock domain for every check
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_bus_zero_wait: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_read_we_high: assert property (
      !fl_output_enable_n |-> !fl_chip_select_n && fl_write_strobe_n)
      else $error("bad read strobes");
   a_read_released: assert property (
      !fl_output_enable_n |-> !fl_dq_oe && (fl_top_oe == !fl_word_mode))
      else $error("data lines driven during a read");
   a_cmd_oe_high: assert property (
      !fl_write_strobe_n |-> fl_output_enable_n && !fl_chip_select_n)
      else $error("bad write strobes");
   a_cmd_driven: assert property (
      !fl_write_strobe_n |-> fl_dq_oe && (fl_word_mode || fl_top_oe))
      else $error("write strobe without driven data");
   a_write_hold: assert property (
      !fl_write_strobe_n |=> $stable(fl_addr) && $stable(fl_dq_out))
      else $error("write data moved");
   a_strobe_short: assert property (
      $fell(fl_write_strobe_n) |-> ##[1:4] fl_write_strobe_n)
      else $error("write strobe held too long");
   a_width_steady: assert property (
      !fl_chip_select_n && $past(!fl_chip_select_n) |-> $stable(fl_word_mode))
      else $error("bus width changed inside a cycle");
   a_byte_addr_pin: assert property (
      !fl_word_mode && !fl_chip_select_n |-> fl_top_oe)
      else $error("low address pin idle");

   c_write: cover property ($fell(fl_write_strobe_n));
   c_byte_read: cover property ($fell(fl_output_enable_n) && !fl_word_mode);
   c_width_swap: cover property (fl_word_mode ##1 !fl_word_mode);
endmodule // bfc_flash_ctrl_properties

bind bfc_flash_ctrl bfc_flash_ctrl_properties
   bfc_flash_ctrl_properties_inst (.*);

// ### sim/bfc_flash_model.sv
// Behavioural flash device: array window, status and command decoding
`timescale 1ns/100ps
`include "bfc_defines.vh"
module bfc_flash_model
#(
   parameter [7:0] MFR_LO  = 8'h3C, // Arbitrary maker code
   parameter [7:0] MFR_HI  = 8'h5A, // Arbitrary upper maker byte
   parameter [7:0] DEV_LO  = 8'hA7, // Arbitrary part code
   parameter [7:0] DEV_HI  = 8'h6B, // Arbitrary upper part byte
   parameter       BUSY_NS = 1500   // Engine run time per job
)
(
   input  wire [16:0] addr,   // Word address pins
   input  wire [15:0] dq_w,   // Data from the controller
   input  wire        top_w,  // Top pin, low address in byte mode
   input  wire        cs_n,   // Chip select
   input  wire        oe_n,   // Output enable
   input  wire        we_n,   // Write strobe
   input  wire        word,   // Bus width, high = 16
   input  wire        wp,     // Write protect pin
   input  wire        unlock, // Reset pin at unlock level
   input  wire        vpp,    // Program supply present
   input  wire        rst_n,  // Reset and power-down
   input  wire        idhv,   // Id voltage on its address pin
   output reg  [15:0] dq_r,   // Data the device drives
   output reg         lo_oe,  // Device drives the low byte
   output reg         hi_oe   // Device drives the high byte
);
   reg [15:0] mem [0:255];    // Array window by low address bits
   reg [7:0]  sr;             // Status register
   reg [7:0]  sr_lat;         // Status held for the current read
   reg [2:0]  mode;           // 0 array, 1 status, 2 id, 3 prog, 4 erase
   reg        busy;           // Engine running
   reg        job_er;         // Job is an erase
   reg        job_hi;         // Byte write hits the upper half
   reg        job_boot;       // Job targets the boot block
   reg [7:0]  job_idx;        // Job word index
   reg [15:0] job_d;          // Job data
   integer    i;
   event      go_ev;
   wire boot = (addr[16:13] == 4'h0); // Bottom 16KB is boot

   // Power-up: erased array, ready, array read mode
   initial
   begin
      for (i = 0; i < 256; i = i + 1)
         mem[i] = 16'hFFFF;
      sr = 8'h80;
      sr_lat = 8'h80;
      mode = 3'h0;
      busy = 1'b0;
   end

   // Checks supply and boot protection, then starts the engine
   task start_job(input er);
      mode = 3'h1;
      if (!vpp)
         sr[3] = 1'b1;
      if (!vpp || (boot && !(wp || unlock)))
         sr[er ? 5 : 4] = 1'b1;
      else
      begin
         job_er = er;
         job_hi = !word && top_w;
         job_boot = boot;
         job_idx = addr[7:0];
         job_d = word ? dq_w : {8'hFF, dq_w[7:0]};
         -> go_ev;
      end
   endtask

   // Decodes a latched cycle; busy honours status only
   task latch;
      if (busy)
         mode = (dq_w[7:0] == `BFC_CMD_STATUS) ? 3'h1 : mode;
      else if (mode == 3'h3)
         start_job(1'b0);
      else if (mode == 3'h4 && dq_w[7:0] == `BFC_CMD_CONFIRM)
         start_job(1'b1);
      else
         case (dq_w[7:0])
            `BFC_CMD_READ:   mode = 3'h0;
            `BFC_CMD_ID:     mode = 3'h2;
            `BFC_CMD_STATUS: mode = 3'h1;
            `BFC_CMD_CLRST:  sr[5:3] = 3'h0;
            `BFC_CMD_ERASE:  mode = 3'h4;
            `BFC_CMD_PROG, `BFC_CMD_PROG_ALT: mode = 3'h3;
            default:         mode = 3'h1;
         endcase
   endtask

   // Latch on whichever of select and strobe rises first
   always @(posedge we_n or posedge cs_n)
      if (rst_n && oe_n && (we_n != cs_n))
         latch;

   // Engine: busy for a while, then applies the job and reports
   always
   begin
      @(go_ev);
      busy = 1'b1;
      sr[7] = 1'b0;
      #(BUSY_NS);
      if (job_boot && !(wp || unlock))
         sr[job_er ? 5 : 4] = 1'b1;
      else if (job_er)
         for (i = 0; i < 256; i = i + 1)
            mem[i] = 16'hFFFF;
      else if (job_hi)
         mem[job_idx][15:8] = mem[job_idx][15:8] & job_d[7:0];
      else
         mem[job_idx] = mem[job_idx] & job_d;
      sr[7] = 1'b1;
      busy = 1'b0;
   end

   // Power-down clears status and returns to array read
   always @(negedge rst_n)
   begin
      sr = 8'h80;
      mode = 3'h0;
   end

   // Status is captured when the later enable falls
   always @(negedge oe_n or negedge cs_n)
      if (!oe_n && !cs_n)
         sr_lat = sr;

   // Read path: id, status or array data
   always @*
   begin
      lo_oe = rst_n && !cs_n && !oe_n && we_n;
      hi_oe = lo_oe && word;
      if (idhv || mode == 3'h2)
         dq_r = addr[0] ? {DEV_HI, DEV_LO} : {MFR_HI, MFR_LO};
      else if (busy || mode == 3'h1)
         dq_r = {8'h00, sr_lat};
      else if (word)
         dq_r = mem[addr[7:0]];
      else
         dq_r = {8'h00, top_w ? mem[addr[7:0]][15:8] : mem[addr[7:0]][7:0]};
   end
endmodule // bfc_flash_model

// ### sim/bfc_flash_ctrl_test.sv
// Testbench: controller registers over AHB-Lite against the flash model
`timescale 1ns/100ps
`include "bfc_defines.vh"
`define CHK(got, exp) begin n_tests = n_tests + 1; if ((got) !== (exp)) \
   begin fails = fails + 1; $display("MISMATCH t=%0t got=%h exp=%h", \
   $time, (got), (exp)); end end
module bfc_flash_ctrl_test;
   reg         hclk, hresetn, hsel, hwrite;  // Bus inputs
   reg  [31:0] haddr, hwdata;
   reg  [1:0]  htrans;
   reg  [2:0]  hsize;
   wire        hreadyout, hresp;              // Bus answer
   wire [31:0] hrdata;
   wire [16:0] fl_addr;                       // Flash pins
   wire [14:0] fl_dq_in, fl_dq_out;
   wire        fl_dq_oe, fl_top_in, fl_top_out, fl_top_oe;
   wire        fl_chip_select_n, fl_output_enable_n, fl_write_strobe_n;
   wire        fl_word_mode, fl_write_protect, fl_unlock_high_voltage;
   wire        fl_program_supply_en, fl_reset_powerdown_n, fl_id_high_voltage;
   wire [15:0] dq_r;                          // Device read data
   wire        lo_oe, hi_oe;                  // Device drive enables
   reg  [14:0] dq_last;                       // Last level, for floating
   reg         top_last;
   reg  [31:0] rd, st;                        // Last read, last status
   integer     fails, n_tests;

   // Undriven lines show the inverse of their last level
   assign fl_dq_in = fl_dq_oe ? fl_dq_out :
                     {hi_oe ? dq_r[14:8] : ~dq_last[14:8],
                      lo_oe ? dq_r[7:0] : ~dq_last[7:0]};
   assign fl_top_in = fl_top_oe ? fl_top_out : hi_oe ? dq_r[15] : ~top_last;
   always @(posedge hclk)
   begin
      dq_last <= fl_dq_in;
      top_last <= fl_top_in;
   end

   bfc_flash_ctrl bfc_flash_ctrl_inst
   (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fl_addr, .fl_dq_in,
      .fl_dq_out, .fl_dq_oe, .fl_top_in, .fl_top_out, .fl_top_oe,
      .fl_chip_select_n, .fl_output_enable_n, .fl_write_strobe_n,
      .fl_word_mode, .fl_write_protect, .fl_unlock_high_voltage,
      .fl_program_supply_en, .fl_reset_powerdown_n, .fl_id_high_voltage
   );

   bfc_flash_model bfc_flash_model_inst
   (
      .addr(fl_addr), .dq_w({fl_top_out, fl_dq_out}), .top_w(fl_top_out),
      .cs_n(fl_chip_select_n), .oe_n(fl_output_enable_n),
      .we_n(fl_write_strobe_n), .word(fl_word_mode), .wp(fl_write_protect),
      .unlock(fl_unlock_high_voltage), .vpp(fl_program_supply_en),
      .rst_n(fl_reset_powerdown_n), .idhv(fl_id_high_voltage),
      .dq_r, .lo_oe, .hi_oe
   );

   // 10 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // Prints the counts and the verdict, then stops
   task summarize;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Waits for hready at a rising edge, bounded
   task wait_ready;
      integer k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && k < 50)
      begin
         @(posedge hclk);
         k = k + 1;
      end
      if (k >= 50)
      begin
         fails = fails + 1;
         summarize;
      end
   endtask

   // One single word transfer: address phase, then data phase
   task ahb(input wr, input [7:0] a, input [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready;
      rd = hrdata;
   endtask

   // Writes the pin control register
   task pins(input [5:0] v);
      ahb(1'b1, `BFC_REG_PINS, {26'h0, v});
   endtask

   // Runs one operation, polls STAT into st, then reads RDATA into rd
   task op(input [2:0] code, input [17:0] a, input [15:0] d);
      integer k;
      k = 0;
      ahb(1'b1, `BFC_REG_ADDR, {14'h0000, a});
      ahb(1'b1, `BFC_REG_WDATA, {16'h0000, d});
      ahb(1'b1, `BFC_REG_CTRL, {28'h0000000, code, 1'b1});
      do
      begin
         ahb(1'b0, `BFC_REG_STAT, 32'h0);
         k = k + 1;
      end
      while (rd[8] !== 1'b0 && k < 200);
      if (rd[8] !== 1'b0)
      begin
         fails = fails + 1;
         summarize;
      end
      st = rd;
      ahb(1'b0, `BFC_REG_RDATA, 32'h0);
   endtask

   // Main sequence
   initial
   begin
      {hsel, hwrite, haddr, hwdata, htrans} = 0;
      hsize = 3'h2;
      hresetn = 1'b0;
      fails = 0;
      n_tests = 0;
      dq_last = 15'h0000;
      top_last = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, `BFC_REG_PINS, 32'h0);
      `CHK(rd[5:0], 6'h11)
      op(`BFC_OP_READ, 18'h30010, 16'h0000);
      `CHK(rd[15:0], 16'hFFFF)
      pins(6'h19);
      op(`BFC_OP_PROG, 18'h30010, 16'h1234);
      `CHK(st[9:0], 10'h080)
      op(`BFC_OP_PROG, 18'h30010, 16'hFF00);
      op(`BFC_OP_READ, 18'h30010, 16'h0000);
      `CHK(rd[15:0], 16'h1200)
      pins(6'h18);
      op(`BFC_OP_READ, 18'h30011, 16'h0000);
      `CHK(rd[15:0], 16'h0012)
      pins(6'h19);
      op(`BFC_OP_PROG, 18'h00020, 16'h00FF);
      `CHK(st[9:0], 10'h290)
      op(`BFC_OP_CLRST, 18'h0, 16'h0000);
      op(`BFC_OP_STATUS, 18'h00020, 16'h0000);
      `CHK(rd[15:0], 16'h0080)
      pins(6'h1B);
      op(`BFC_OP_PROG, 18'h00020, 16'h00FF);
      `CHK(st[9:0], 10'h080)
      pins(6'h1D);
      op(`BFC_OP_PROG, 18'h00020, 16'h000F);
      `CHK(st[9:0], 10'h080)
      pins(6'h11);
      op(`BFC_OP_PROG, 18'h30010, 16'h0000);
      `CHK(st[9:0], 10'h298)
      pins(6'h01);
      pins(6'h11);
      op(`BFC_OP_STATUS, 18'h0, 16'h0000);
      `CHK(rd[15:0], 16'h0080)
      op(`BFC_OP_ID, 18'h00000, 16'h0000);
      `CHK(rd[15:0], 16'h003C)
      op(`BFC_OP_ID, 18'h00002, 16'h0000);
      `CHK(rd[15:0], 16'h00A7)
      pins(6'h31);
      op(`BFC_OP_READ, 18'h30010, 16'h0000);
      `CHK(rd[15:0], 16'h5A3C)
      pins(6'h19);
      op(`BFC_OP_ERASE, 18'h30010, 16'h0000);
      `CHK(st[9:0], 10'h080)
      op(`BFC_OP_READ, 18'h30010, 16'h0000);
      `CHK(rd[15:0], 16'hFFFF)
      ahb(1'b0, 8'h40, 32'h0);
      `CHK(rd, 32'h00000000)
      summarize;
   end
endmodule // bfc_flash_ctrl_test
